// ---- hw/vectored_interrupt_unit.v ----
// vectored interrupt unit: flags, masks, priority and core entry handshake
// Overview of operation
// - accept pushes return address, loads vector
// - entry clears global enable automatically
// - flags still set while globally disabled
// - full stack blocks acknowledge of requests
// - vector jump after 2 cycles, 3 from sleep
// - requests sampled once per phase two pulse
// - fixed priority: pin 04h, t0 08h, t1 0ch
// - converter 10h fourth, time base 14h
// - external beats simultaneous internal request
// - global enable zero blocks all service
// - pin service needs global and pin enable
// - edge field bits 7:6 select edge
// - pin service clears its flag, global enable
// - qualifying pin edge calls vector 04h
// - pull-high stays on as interrupt input
// - return pops saved counter, resumes
// - flag holds until serviced or cleared
// - any flagged source with its own enable set wakes from sleep
// - timer service clears flag and global enable
// - global bit0, pin enable bit1, flag bit4
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`include "vectored_irq_defines.vh"
module vectored_interrupt_unit #(
    parameter HAS_CONVERTER = 1 // converter source present
) (
    input wire clk_sys, // system clock
    input wire rst_b, // async reset, active low
    // classic wishbone slave
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_we_i, // write enable
    input wire [3:0] wb_adr_i, // byte address
    input wire [3:0] wb_sel_i, // byte selects
    input wire [31:0] wb_dat_i, // write data
    output reg [31:0] wb_dat_o, // read data
    output wire wb_ack_o, // acknowledge
    // event sources
    input wire port_a_line_three, // shared pin level
    input wire port_a_pull_high_en, // pull-high selection
    output wire port_a_pull_high, // pull-high drive
    input wire timer0_overflow, // overflow pulse
    input wire timer1_overflow, // overflow pulse
    input wire converter_done, // conversion complete pulse
    input wire time_base_overflow, // time base pulse
    // core interface
    input wire phase_two_pulse, // one pulse per instruction cycle
    input wire core_sleeping, // core in sleep mode
    input wire [10:0] next_pc, // address of next instruction
    input wire stack_full, // hardware stack full
    input wire reti_exec, // return-from-interrupt executed
    input wire [10:0] stack_top, // saved counter at top of stack
    output reg wake_req, // wake core from sleep
    output reg stack_push, // push pulse
    output reg [10:0] push_data, // value to push
    output reg pc_load, // load counter pulse
    output reg [10:0] pc_value // value to load
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // entry sequence: idle, counting phase pulses, then push and load together
    localparam IDLE = 2'h0;
    localparam WAIT = 2'h1;
    localparam JUMP = 2'h2;
    reg global_irq_enable;
    reg pin_irq_enable;
    reg t0_irq_enable;
    reg t1_irq_enable;
    reg converter_irq_enable;
    reg time_base_irq_enable;
    reg [4:0] flags;
    reg edge_select_low;
    reg edge_select_high;
    reg pin_prev;
    reg ack;
    reg [1:0] state;
    reg [1:0] cycles;
    reg [4:0] held_grant;
    reg [10:0] held_vector;
    wire [4:0] enables;
    wire [4:0] pending;
    wire any;
    wire [4:0] grant;
    wire [10:0] vector;
    wire rise;
    wire fall;
    wire pin_edge;
    wire wr;
    wire [4:0] events;
    reg [4:0] sw_clear;
    wire [4:0] svc_clear;
    wire en_wr;
    wire wr_second;
    wire wr_one;
    // ------------------------------------------------------------
    // wishbone slave: one-wait-state ack, dropped after one cycle
    // ------------------------------------------------------------
    // registered ack: a write lands at the edge that raises ack, and read data
    // is loaded at that same edge so it stands while ack is high
    assign wb_ack_o = ack;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack & wb_sel_i[0];
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= wb_cyc_i & wb_stb_i & ~ack;
        end
    end
    function [7:0] bitval;
        input integer pos;
        input v;
        begin
            bitval = `REG_ZERO;
            bitval[pos] = v;
        end
    endfunction
    // one shared decode so every register sees the same write qualifier
    function reg_hit;
        input [3:0] adr;
        input [3:0] target;
        begin
            reg_hit = (adr == target);
        end
    endfunction
    // unmapped offsets and every bit above the low byte read as zero
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= 32'h00000000;
            case (wb_adr_i)
                `ADDR_IRQ_CONTROL_FIRST: begin
                    wb_dat_o[7:0] <= bitval(`BIT_GLOBAL_EN, global_irq_enable)
                        | bitval(`BIT_PIN_EN, pin_irq_enable)
                        | bitval(`BIT_T0_EN, t0_irq_enable)
                        | bitval(`BIT_T1_EN, t1_irq_enable)
                        | bitval(`BIT_PIN_FLAG, flags[`SRC_PIN])
                        | bitval(`BIT_T0_FLAG, flags[`SRC_T0])
                        | bitval(`BIT_T1_FLAG, flags[`SRC_T1]);
                end
                `ADDR_IRQ_CONTROL_SECOND: begin
                    wb_dat_o[7:0] <= bitval(`BIT_CONV_EN, converter_irq_enable)
                        | bitval(`BIT_TB_EN, time_base_irq_enable)
                        | bitval(`BIT_CONV_FLAG, flags[`SRC_CONV])
                        | bitval(`BIT_TB_FLAG, flags[`SRC_TB]);
                end
                `ADDR_CONTROL_REG_ONE: begin
                    wb_dat_o[7:0] <= bitval(`BIT_EDGE_LOW, edge_select_low)
                        | bitval(`BIT_EDGE_HIGH, edge_select_high);
                end
                `ADDR_CORE_STATUS: begin
                    wb_dat_o[1:0] <= state;
                end
                default: begin
                    wb_dat_o <= 32'h00000000;
                end
            endcase
        end
    end
    // software clears: writing 0 to a flag bit clears it; an event wins
    always @* begin
        sw_clear = 5'h00;
        if (en_wr) begin
            sw_clear[`SRC_PIN] = ~wb_dat_i[`BIT_PIN_FLAG];
            sw_clear[`SRC_T0] = ~wb_dat_i[`BIT_T0_FLAG];
            sw_clear[`SRC_T1] = ~wb_dat_i[`BIT_T1_FLAG];
        end
        if (wr_second) begin
            sw_clear[`SRC_CONV] = ~wb_dat_i[`BIT_CONV_FLAG];
            sw_clear[`SRC_TB] = ~wb_dat_i[`BIT_TB_FLAG];
        end
    end
    assign en_wr = wr && reg_hit(wb_adr_i, `ADDR_IRQ_CONTROL_FIRST);
    assign wr_second = wr && reg_hit(wb_adr_i, `ADDR_IRQ_CONTROL_SECOND);
    assign wr_one = wr && reg_hit(wb_adr_i, `ADDR_CONTROL_REG_ONE);
    // ------------------------------------------------------------
    // pin edge qualifier
    // ------------------------------------------------------------
    assign port_a_pull_high = port_a_pull_high_en;
    // pin_prev resets low, the idle level of the pin, so reset gives no false edge
    assign rise = port_a_line_three & ~pin_prev;
    assign fall = ~port_a_line_three & pin_prev;
    assign pin_edge = (edge_select_low & rise) | (edge_select_high & fall);
    // without a converter its event is masked, and the time base keeps 14h
    assign events = {time_base_overflow, converter_done & (HAS_CONVERTER != 0),
                     timer1_overflow, timer0_overflow, pin_edge};
    // ------------------------------------------------------------
    // enable and flag storage
    // ------------------------------------------------------------
    // service clears only the granted source; the others wait for the next entry
    assign svc_clear = (state == JUMP) ? held_grant : 5'h00;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_enable <= 1'b0;
            pin_irq_enable <= 1'b0;
            t0_irq_enable <= 1'b0;
            t1_irq_enable <= 1'b0;
            converter_irq_enable <= 1'b0;
            time_base_irq_enable <= 1'b0;
            edge_select_low <= 1'b0;
            edge_select_high <= 1'b0;
            flags <= 5'h00;
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= port_a_line_three;
            // flags set regardless of enables; set beats any clear
            flags <= events | (flags & ~sw_clear & ~svc_clear);
            // the clear on entry wins over a software write in the same cycle
            if (state == JUMP) begin
                global_irq_enable <= 1'b0;
            end else if (en_wr) begin
                global_irq_enable <= wb_dat_i[`BIT_GLOBAL_EN];
            end
            if (en_wr) begin
                pin_irq_enable <= wb_dat_i[`BIT_PIN_EN];
                t0_irq_enable <= wb_dat_i[`BIT_T0_EN];
                t1_irq_enable <= wb_dat_i[`BIT_T1_EN];
            end
            if (wr_second) begin
                converter_irq_enable <= wb_dat_i[`BIT_CONV_EN] & (HAS_CONVERTER != 0);
                time_base_irq_enable <= wb_dat_i[`BIT_TB_EN];
            end
            if (wr_one) begin
                edge_select_low <= wb_dat_i[`BIT_EDGE_LOW];
                edge_select_high <= wb_dat_i[`BIT_EDGE_HIGH];
            end
        end
    end
    // ------------------------------------------------------------
    // selection and core entry
    // ------------------------------------------------------------
    assign enables = {time_base_irq_enable, converter_irq_enable,
                      t1_irq_enable, t0_irq_enable, pin_irq_enable};
    // a source is pending only with its own enable and the global enable set
    assign pending = flags & enables & {`NUM_SRC{global_irq_enable}};
    irq_priority_pick u_pick (
        .pending(pending),
        .any(any),
        .grant(grant),
        .vector(vector)
    );
    // the winner is latched at the phase pulse; a later higher request waits
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= IDLE;
            cycles <= 2'h0;
            held_grant <= 5'h00;
            held_vector <= `VEC_PIN;
            stack_push <= 1'b0;
            push_data <= 11'h000;
            pc_load <= 1'b0;
            pc_value <= 11'h000;
            wake_req <= 1'b0;
        end else begin
            stack_push <= 1'b0;
            pc_load <= 1'b0;
            // wake ignores the global enable so a masked source still ends sleep
            wake_req <= |(flags & enables);
            case (state)
                IDLE: begin
                    // a return is served only in idle; one that arrives mid-entry
                    // is lost, a limit the core must respect
                    if (reti_exec) begin
                        pc_load <= 1'b1;
                        pc_value <= stack_top;
                    end else if (phase_two_pulse && any && !stack_full) begin
                        held_grant <= grant;
                        held_vector <= vector;
                        cycles <= core_sleeping ? `WAKE_CYCLES - 2'h1
                                                : `ENTRY_CYCLES - 2'h1;
                        state <= WAIT;
                    end
                end
                WAIT: begin
                    // count phase pulses, not clocks, so the delay follows the cycle
                    if (phase_two_pulse) begin
                        if (cycles == 2'h1) begin
                            state <= JUMP;
                        end else begin
                            cycles <= cycles - 2'h1;
                        end
                    end
                end
                JUMP: begin
                    // push and load leave on one edge so the core never sees half an entry
                    stack_push <= 1'b1;
                    push_data <= next_pc;
                    pc_load <= 1'b1;
                    pc_value <= held_vector;
                    state <= IDLE;
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule // vectored_interrupt_unit

// ---- hw/vectored_irq_defines.vh ----
// constants for the vectored interrupt unit
`ifndef VECTORED_IRQ_DEFINES_VH
`define VECTORED_IRQ_DEFINES_VH
// register byte addresses on the wishbone bus (word aligned)
`define ADDR_IRQ_CONTROL_FIRST 4'h0
`define ADDR_IRQ_CONTROL_SECOND 4'h4
`define ADDR_CONTROL_REG_ONE 4'h8
`define ADDR_CORE_STATUS 4'hc
// first control register bits
`define BIT_GLOBAL_EN 0
`define BIT_PIN_EN 1
`define BIT_T0_EN 2
`define BIT_T1_EN 3
`define BIT_PIN_FLAG 4
`define BIT_T0_FLAG 5
`define BIT_T1_FLAG 6
// second control register bits
`define BIT_CONV_EN 0
`define BIT_TB_EN 1
`define BIT_CONV_FLAG 4
`define BIT_TB_FLAG 5
// control register one edge field
`define BIT_EDGE_LOW 6
`define BIT_EDGE_HIGH 7
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
// vectors
`define VEC_PIN 11'h004
`define VEC_T0 11'h008
`define VEC_T1 11'h00c
`define VEC_CONV 11'h010
`define VEC_TB 11'h014
// source indices, priority order
`define SRC_PIN 0
`define SRC_T0 1
`define SRC_T1 2
`define SRC_CONV 3
`define SRC_TB 4
`define NUM_SRC 5
// entry delay in instruction cycles
`define ENTRY_CYCLES 2'h2
`define WAKE_CYCLES 2'h3
`define REG_ZERO 8'h00
`endif

// ---- hw/irq_priority_pick.v ----
// fixed priority selector: lowest index wins, returns vector and one-hot grant
`include "vectored_irq_defines.vh"
module irq_priority_pick (
    input wire [4:0] pending, // enabled pending requests
    output reg any, // at least one request
    output reg [4:0] grant, // one-hot winner
    output reg [10:0] vector // vector of winner
);
    always @* begin
        any = 1'b1;
        grant = 5'h00;
        vector = `VEC_PIN;
        if (pending[`SRC_PIN]) begin
            grant[`SRC_PIN] = 1'b1;
        end else if (pending[`SRC_T0]) begin
            grant[`SRC_T0] = 1'b1;
            vector = `VEC_T0;
        end else if (pending[`SRC_T1]) begin
            grant[`SRC_T1] = 1'b1;
            vector = `VEC_T1;
        end else if (pending[`SRC_CONV]) begin
            grant[`SRC_CONV] = 1'b1;
            vector = `VEC_CONV;
        end else if (pending[`SRC_TB]) begin
            grant[`SRC_TB] = 1'b1;
            vector = `VEC_TB;
        end else begin
            any = 1'b0;
        end
    end
endmodule // irq_priority_pick

// ---- sim/irq_chk.sv ----
// port checker for the vectored interrupt unit
module irq_chk (
    input wire clk_sys, // clock
    input wire rst_b, // reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_ack_o, // ack
    input wire [31:0] wb_dat_o, // rdata
    input wire port_a_pull_high_en, // pull req
    input wire port_a_pull_high, // pull
    input wire phase_two_pulse, // phase
    input wire [10:0] next_pc, // pc
    input wire stack_full, // full
    input wire reti_exec, // return
    input wire [10:0] stack_top, // top
    input wire stack_push, // push
    input wire [10:0] push_data, // pushed
    input wire pc_load, // load
    input wire [10:0] pc_value // loaded
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // helpers
    // ----------
    int unsigned full_cnt;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // an entry accepted just before the stack filled may still finish
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            full_cnt <= 0;
        end else begin
            full_cnt <= stack_full ? full_cnt + 1 : 0;
        end
    end
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_one_shot;
        pc_load ##1 (!stack_push && !pc_load);
    endsequence
    // ----------
    // assertions
    // ----------
    a_push_load: assert property (stack_push |-> s_one_shot)
        else $error("push without single load");
    a_push_value: assert property (stack_push |-> push_data == next_pc)
        else $error("pushed value wrong");
    a_entry_phase: assert property (stack_push |-> $past(phase_two_pulse, 2))
        else $error("entry off phase");
    a_vector_legal: assert property (stack_push |-> pc_value inside
        {11'h004, 11'h008, 11'h00c, 11'h010, 11'h014})
        else $error("illegal vector");
    a_full_block: assert property (full_cnt > 12 |-> !stack_push)
        else $error("push while full");
    a_return_pop: assert property (pc_load && !stack_push |->
        $past(reti_exec) && pc_value == $past(stack_top))
        else $error("bad return load");
    a_pull_keep: assert property (port_a_pull_high == port_a_pull_high_en)
        else $error("pull-high lost");
    a_bus_ack: assert property (s_bus_req |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule // irq_chk
bind vectored_interrupt_unit irq_chk u_chk (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .port_a_pull_high_en, .port_a_pull_high, .phase_two_pulse,
    .next_pc, .stack_full, .reti_exec, .stack_top, .stack_push, .push_data, .pc_load,
    .pc_value);

// ---- sim/core_model.sv ----
// behavioural core: phase pulse, program counter and return stack
module core_model #(
    parameter int DEPTH = 6
) (
    input wire clk_sys, // clock
    input wire rst_b, // reset
    input wire stack_push, // push
    input wire [10:0] push_data, // pushed
    input wire pc_load, // load
    input wire [10:0] pc_value, // loaded
    input wire reti_req, // bench return
    output logic phase_two_pulse, // phase
    output logic [10:0] next_pc, // pc
    output wire stack_full, // full
    output logic reti_exec, // return
    output wire [10:0] stack_top // top
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] mem [0:7];
    int sp;
    logic [1:0] ph;
    assign stack_full = (sp == DEPTH);
    // empty stack shows a moving value, not a stale one
    assign stack_top = (sp > 0) ? mem[sp - 1] : ~next_pc;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sp <= 0;
            ph <= 2'h0;
            phase_two_pulse <= 1'b0;
            next_pc <= 11'h000;
            reti_exec <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            phase_two_pulse <= (ph == 2'h3);
            reti_exec <= reti_req && !reti_exec;
            if (pc_load) begin
                next_pc <= pc_value;
            end else if (phase_two_pulse) begin
                next_pc <= next_pc + 11'h001;
            end
            if (stack_push) begin
                mem[sp] <= push_data;
                sp <= sp + 1;
            end else if (reti_exec) begin
                sp <= sp - 1;
            end
        end
    end
endmodule // core_model

// ---- sim/vectored_interrupt_unit_tb_top.sv ----
// self-checking bench for the vectored interrupt unit
`include "vectored_irq_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module vectored_interrupt_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = '0, rst_b = '0, cyc = '0, we = '0, pin = '0, pull_en = '0;
    logic sleep = '0, reti_req = '0, ack, p2, full, reti, push, load, wake;
    logic [3:0] adr = '0, evt = '0;
    logic [7:0] wdat = '0, f0 = '0, f1 = '0;
    logic [31:0] q, rdat;
    logic [10:0] npc, top, pdat, pval, pushed[$];
    int n_mismatch = 0, checked = 0, n_push = 0, n, n_p2 = 0, p2_mark = 0;
    logic [10:0] vec[5] = '{`VEC_PIN, `VEC_T0, `VEC_T1, `VEC_CONV, `VEC_TB};
    logic [7:0] fb0[5] = '{8'h10, 8'h20, 8'h40, 8'h00, 8'h00};
    logic [7:0] fb1[5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h20};
    logic [3:0] ra[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (push === 1'b1) n_push++;
    // counts phase pulses strictly before the current edge
    always @(posedge clk_sys) if (p2 === 1'b1) n_p2 <= n_p2 + 1;
    vectored_interrupt_unit u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wdat}),
        .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_line_three(pin), .port_a_pull_high_en(pull_en),
        .port_a_pull_high(), .timer0_overflow(evt[0]), .timer1_overflow(evt[1]),
        .converter_done(evt[2]), .time_base_overflow(evt[3]), .phase_two_pulse(p2),
        .core_sleeping(sleep), .next_pc(npc), .stack_full(full), .reti_exec(reti),
        .stack_top(top), .wake_req(wake), .stack_push(push), .push_data(pdat), .pc_load(load),
        .pc_value(pval));
    core_model u_core (.clk_sys(clk_sys), .rst_b(rst_b), .stack_push(push), .push_data(pdat),
        .pc_load(load), .pc_value(pval), .reti_req(reti_req), .phase_two_pulse(p2),
        .next_pc(npc), .stack_full(full), .reti_exec(reti), .stack_top(top));
    // ----------
    // tasks
    // ----------
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        pull_en <= 1'($urandom);
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        p2_mark = n_p2;
        if (k >= 50) n_mismatch++;
        cyc <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        wb(1'b1, a, v);
        if (a == 4'h0) f0 = (v & 8'h0f) | (f0 & v & 8'h70);
        if (a == 4'h4) f1 = (v & 8'h03) | (f1 & v & 8'h30);
    endtask
    task automatic regs();
        wb(1'b0, 4'h0, 8'h0);
        `CHK(q, {24'h0, f0})
        wb(1'b0, 4'h4, 8'h0);
        `CHK(q, {24'h0, f1})
    endtask
    task automatic ev(input logic [3:0] m);
        evt <= m;
        @(posedge clk_sys);
        evt <= 4'h0;
        repeat (2) @(posedge clk_sys);
        f0 = f0 | {1'b0, m[1], m[0], 5'h0};
        f1 = f1 | {2'h0, m[3], m[2], 4'h0};
    endtask
    task automatic pn(input logic v);
        pin <= v;
        repeat (5) @(posedge clk_sys);
    endtask
    task automatic take(input int k);
        int c;
        c = 0;
        while (push !== 1'b1 && c < 60) begin
            @(posedge clk_sys);
            c++;
        end
        `CHK(pval, vec[k])
        `CHK(pdat, npc)
        `CHK(n_p2 - p2_mark, sleep ? `WAKE_CYCLES : `ENTRY_CYCLES)
        pushed.push_back(npc);
        f0 = f0 & ~(8'h01 | fb0[k]);
        f1 = f1 & ~fb1[k];
        @(posedge clk_sys);
    endtask
    task automatic ret();
        logic [10:0] e;
        int c;
        c = 0;
        e = pushed.pop_back();
        reti_req <= 1'b1;
        @(posedge clk_sys);
        reti_req <= 1'b0;
        while (!(load === 1'b1 && push !== 1'b1) && c < 20) begin
            @(posedge clk_sys);
            c++;
        end
        p2_mark = n_p2;
        `CHK(pval, e)
        @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----------
    // main
    // ----------
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end
    initial begin
        void'($urandom(59));
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        foreach (ra[i]) begin
            wb(1'b0, ra[i], 8'h0);
            `CHK(q, 32'h0)
        end
        ev(4'hf);
        regs();
        `CHK(wake, 1'b0)
        wr(4'h4, 8'h33);
        wr(4'h0, 8'h7f);
        for (int k = 1; k < 5; k++) begin
            take(k);
            regs();
            n = n_push;
            repeat (12) @(posedge clk_sys);
            `CHK(n_push, n)
            wr(4'h0, f0 | 8'h01);
        end
        wr(4'h0, 8'h0e);
        for (int m = 0; m < 4; m++) begin
            wr(4'h8, 8'(m << 6));
            for (int d = 1; d >= 0; d--) begin
                pn(1'(d));
                if (m[1 - d]) f0 = f0 | 8'h10;
                regs();
                wr(4'h0, 8'h0e);
            end
        end
        wr(4'h8, 8'h40);
        wr(4'h0, 8'h06);
        pn(1'b1);
        f0 = f0 | 8'h10;
        ev(4'h1);
        wr(4'h0, f0 | 8'h01);
        take(0);
        regs();
        wr(4'h0, f0 | 8'h01);
        take(1);
        ev(4'h2);
        wr(4'h0, f0 | 8'h09);
        n = n_push;
        repeat (30) @(posedge clk_sys);
        `CHK(n_push, n)
        ret();
        take(2);
        repeat (6) ret();
        sleep <= 1'b1;
        ev(4'h8);
        `CHK(wake, 1'b1)
        wr(4'h0, f0 | 8'h01);
        take(4);
        sleep <= 1'b0;
        ret();
        finish_test();
    end
endmodule // vectored_interrupt_unit_tb_top
